// ==== ccrf_core_regs.sv ====
// core register set: data registers, banked stacks, link, address, status
// How it works
// [RQ1] thirteen 32-bit data registers, no reset value, usable in both modes
// [RQ2] register 13 is stack pointer; control bit 1 picks process stack
// [RQ3] after reset fetch word at address zero into main stack pointer
// [RQ4] register 14 holds return link, undefined after reset
// [RQ5] register 15 is instruction address, loaded from word at address four
// [RQ6] reset vector bit 0 goes into execution state bit
// [RQ7] execution state bit sits at position 24
// [RQ8] status word is one 32-bit register of three disjoint fields
// [RQ9] special moves address any single view, pair, or all three
// [RQ10] writes never change the active exception number field
// [RQ11] state field reads zero via moves and ignores writes
// [RQ12] flags at bits 31..28, bits below reserved
// [RQ13] bits 5..0 hold the active exception number
// [RQ14] state bit follows branches, pops, returns and vector entry
// [RQ15] executing with state bit zero raises fault escalation
// [RQ16] interrupted block transfer restarts from its first transfer
// [RQ17] stacked status word carries true state bit
// [RQ18] in handler mode stack select reads zero, main stack used
// [RQ19] reserved bits of every view read zero and ignore writes
`timescale 1ns/1ps
module ccrf_core_regs
  import ccrf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // reset vector fetch
  output logic vecReq,
  output logic [31:0] vecAddr,
  input wire logic vecValid,
  input wire logic [31:0] vecData,
  // register read ports
  input wire logic [3:0] rdIdxA,
  input wire logic [3:0] rdIdxB,
  output logic [31:0] rdDataA,
  output logic [31:0] rdDataB,
  // register write port
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [31:0] wrData,
  // program address update and interworking branch
  input wire logic iaddrWe,
  input wire logic [31:0] iaddrIn,
  input wire logic xchgBranch,
  // condition flags from the execution unit
  input wire logic flagsWe,
  input wire logic [3:0] flagsIn,
  // special-register moves
  input wire logic moveToEn,
  input wire ccrf_view_t moveView,
  input wire logic [31:0] moveToData,
  output logic [31:0] moveFromData,
  // exception entry and return
  input wire logic excEntry,
  input wire logic [5:0] excEntryNum,
  input wire logic [31:0] excVector,
  input wire logic excReturn,
  input wire logic [31:0] excRestoreWord,
  input wire logic excRetThread,
  input wire logic excRetProcess,
  output logic [31:0] stackedWord,
  // block transfer tracking
  input wire logic blockStart,
  input wire logic [31:0] blockAddr,
  input wire logic blockDone,
  output logic [31:0] resumeAddr,
  // execution status
  input wire logic execAttempt,
  output logic stateFault,
  output logic coreRunning,
  output logic handlerMode,
  output logic processStackSel,
  output logic [31:0] iaddr
);
  // ----------------------------------------------------------------
  // reset sequencing
  // ----------------------------------------------------------------
  ccrf_rst_t rst_r, rst_nxt;
  logic [31:0] msp_r, msp_nxt;
  logic [31:0] psp_r, psp_nxt;
  logic [31:0] link_r, link_nxt;
  logic [31:0] iaddr_r, iaddr_nxt;
  logic spsel_r, spsel_nxt;
  logic [31:0] blockPc_r, blockPc_nxt;
  logic blockBusy_r, blockBusy_nxt;
  logic fault_r;

  wire fetchSp = (rst_r == RST_FETCH_SP);
  wire fetchPc = (rst_r == RST_FETCH_PC);
  wire running = (rst_r == RST_RUN);

  // reset vector fetch order: stack word first, then start address
  always_comb begin
    case (rst_r)
      RST_FETCH_SP: rst_nxt = vecValid ? RST_FETCH_PC : RST_FETCH_SP;
      RST_FETCH_PC: rst_nxt = vecValid ? RST_RUN : RST_FETCH_PC;
      RST_RUN: rst_nxt = RST_RUN;
      default: rst_nxt = RST_FETCH_SP;
    endcase
  end

  assign vecReq = fetchSp || fetchPc;
  assign vecAddr = fetchPc ? RESET_VEC_ADDR : MSP_VEC_ADDR; // [RQ3] [RQ5]

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  logic [3:0] flags;
  logic [5:0] excNum;
  logic tstate;
  logic [31:0] trueWord;
  wire inHandler = (excNum != EXC_THREAD);
  wire vecLoad = fetchPc && vecValid;
  // interworking branch or pop to address register sets state from bit 0
  wire tWe = running && ((iaddrWe && xchgBranch) || excEntry);
  wire tIn = excEntry ? excVector[0] : iaddrIn[0]; // [RQ14]
  wire moveCtl = running && moveToEn && (moveView == VIEW_CONTROL);

  ccrf_status_word u_status (
    .clock(clock),
    .reset_n(reset_n),
    .vecLoad(vecLoad),
    .vecBit0(vecData[0]),
    .flagsWe(running && flagsWe),
    .flagsIn(flagsIn),
    .excWe(running && excEntry),
    .excIn(excEntryNum),
    .tstateWe(tWe),
    .tstateIn(tIn),
    .restoreWe(running && excReturn),
    .restoreWord(excRestoreWord),
    .moveWe(running && moveToEn && (moveView != VIEW_CONTROL)),
    .moveView(moveView),
    .moveData(moveToData),
    .flags(flags),
    .excNum(excNum),
    .tstate(tstate),
    .trueWord(trueWord)
  );

  // ----------------------------------------------------------------
  // stack pointer banking
  // ----------------------------------------------------------------
  // handler mode forces the main stack [RQ18]
  wire useProcess = spsel_r && !inHandler; // [RQ2]
  wire spWrite = running && wrEn && (wrIdx == IDX_SP);
  wire [31:0] spValue = useProcess ? psp_r : msp_r;

  always_comb begin
    msp_nxt = msp_r;
    psp_nxt = psp_r;
    if (fetchSp && vecValid) begin
      msp_nxt = vecData; // [RQ3]
    end else if (spWrite && !useProcess) begin
      msp_nxt = wrData;
    end else if (spWrite) begin
      psp_nxt = wrData;
    end
  end

  // control select bit: writes ignored in handler mode, return to thread restores
  always_comb begin
    spsel_nxt = spsel_r;
    if (moveCtl && !inHandler) begin
      spsel_nxt = moveToData[CTRL_SPSEL_POS]; // [RQ18]
    end
    if (running && excReturn && excRetThread) begin
      spsel_nxt = excRetProcess;
    end
  end

  // ----------------------------------------------------------------
  // link and instruction address registers
  // ----------------------------------------------------------------
  always_comb begin
    link_nxt = link_r;
    if (running && wrEn && (wrIdx == IDX_LINK)) begin
      link_nxt = wrData; // [RQ4]
    end
  end

  always_comb begin
    iaddr_nxt = iaddr_r;
    if (vecLoad) begin
      iaddr_nxt = {vecData[31:1], 1'b0}; // [RQ5]
    end else if (running && excEntry) begin
      iaddr_nxt = {excVector[31:1], 1'b0};
    end else if (running && iaddrWe) begin
      iaddr_nxt = {iaddrIn[31:1], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // block transfer restart
  // ----------------------------------------------------------------
  always_comb begin
    blockPc_nxt = blockPc_r;
    blockBusy_nxt = blockBusy_r;
    if (running && blockStart) begin
      blockPc_nxt = blockAddr;
      blockBusy_nxt = 1'b1;
    end else if (running && (blockDone || excEntry)) begin
      blockBusy_nxt = 1'b0; // abandoned on interrupt [RQ16]
    end
  end

  // stacked return address points at the first transfer again
  assign resumeAddr = blockBusy_r ? blockPc_r : iaddr_r; // [RQ16]

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rst_r <= RST_FETCH_SP;
      spsel_r <= 1'b0;
      blockBusy_r <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      rst_r <= rst_nxt;
      spsel_r <= spsel_nxt;
      blockBusy_r <= blockBusy_nxt;
      fault_r <= running && execAttempt && !tstate; // [RQ15]
    end
  end

  // undefined-after-reset registers carry no reset [RQ4]
  always_ff @(posedge clock) begin
    msp_r <= msp_nxt;
    psp_r <= psp_nxt;
    link_r <= link_nxt;
    iaddr_r <= iaddr_nxt;
    blockPc_r <= blockPc_nxt;
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  logic [31:0] gprA, gprB;

  ccrf_gpr_bank #(
    .WIDTH(DATA_W),
    .COUNT(GPR_COUNT)
  ) u_gpr (
    .clock(clock),
    .wrEn(running && wrEn), // [RQ1]
    .wrIdx(wrIdx),
    .wrData(wrData),
    .rdIdxA(rdIdxA),
    .rdIdxB(rdIdxB),
    .rdDataA(gprA),
    .rdDataB(gprB)
  );

  function automatic logic [31:0] read_reg(input logic [3:0] idx,
      input logic [31:0] gpr, input logic [31:0] sp,
      input logic [31:0] lr, input logic [31:0] pc);
    case (idx)
      IDX_SP: read_reg = sp;
      IDX_LINK: read_reg = lr;
      IDX_IADDR: read_reg = pc;
      default: read_reg = gpr;
    endcase
  endfunction

  assign rdDataA = read_reg(rdIdxA, gprA, spValue, link_r, iaddr_r);
  assign rdDataB = read_reg(rdIdxB, gprB, spValue, link_r, iaddr_r);

  // ----------------------------------------------------------------
  // special reads and outputs
  // ----------------------------------------------------------------
  // state bit masked from software view [RQ11] [RQ19]
  wire [31:0] ctlWord = {30'h0, useProcess, 1'b0}; // [RQ18]
  assign moveFromData = (moveView == VIEW_CONTROL) ? ctlWord :
      (trueWord & view_mask(moveView) & ~TSTATE_MASK); // [RQ9]
  assign stackedWord = trueWord; // [RQ17]
  assign stateFault = fault_r;
  assign coreRunning = running;
  assign handlerMode = inHandler;
  assign processStackSel = useProcess;
  assign iaddr = iaddr_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_msp_from_vector: assert property (@(posedge clock) disable iff (!reset_n)
    fetchSp && vecValid |=> msp_r == $past(vecData)) // [RQ3]
    else $error("main stack not loaded from vector");
  a_iaddr_vec_load: assert property (@(posedge clock) disable iff (!reset_n)
    vecLoad |=> iaddr_r[31:1] == $past(vecData[31:1])) // [RQ5]
    else $error("address not loaded from reset vector");
  a_tbit_vec_load: assert property (@(posedge clock) disable iff (!reset_n)
    vecLoad |=> tstate == $past(vecData[0])) // [RQ6]
    else $error("state bit not copied from vector");
  a_handler_main_sp: assert property (@(posedge clock) disable iff (!reset_n)
    inHandler |-> !useProcess && ctlWord == 32'h00000000) // [RQ18]
    else $error("handler mode not on main stack");
  a_state_reads_zero: assert property (@(posedge clock) disable iff (!reset_n)
    moveFromData[TSTATE_POS] == 1'b0) // [RQ11]
    else $error("state bit visible to software");
  a_stacked_true_t: assert property (@(posedge clock) disable iff (!reset_n)
    stackedWord[TSTATE_POS] == tstate) // [RQ17]
    else $error("stacked word lost state bit");
  a_fault_on_t0: assert property (@(posedge clock) disable iff (!reset_n)
    running && execAttempt && !tstate |=> stateFault) // [RQ15]
    else $error("no fault with state bit clear");
  a_block_restart: assert property (@(posedge clock) disable iff (!reset_n)
    running && blockStart ##1 (!blockDone && !blockStart && !excEntry)
    ##1 (!blockDone && !blockStart)
    |-> resumeAddr == $past(blockAddr, 2)) // [RQ16]
    else $error("resume address not block start");
  a_xchg_clears_t: assert property (@(posedge clock) disable iff (!reset_n)
    running && iaddrWe && xchgBranch && !excEntry && !iaddrIn[0]
    |=> !tstate) // [RQ14]
    else $error("exchanging branch left state set");
  // mode, entry, return, stack write and fetch order checks
  a_ctl_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    moveCtl && inHandler && !excReturn |=> $stable(spsel_r)) // [RQ18]
    else $error("control write taken in handler mode");
  a_exc_on_entry: assert property (@(posedge clock) disable iff (!reset_n)
    running && excEntry |=> excNum == $past(excEntryNum)) // [RQ13]
    else $error("exception number not taken on entry");
  a_exc_on_return: assert property (@(posedge clock) disable iff (!reset_n)
    running && excReturn && !excEntry
    |=> excNum == $past(excRestoreWord[EXC_W-1:0])) // [RQ13]
    else $error("exception number not restored on return");
  a_psp_write: assert property (@(posedge clock) disable iff (!reset_n)
    spWrite && useProcess |=> psp_r == $past(wrData)) // [RQ2]
    else $error("process stack not written");
  a_fetch_order: assert property (@(posedge clock) disable iff (!reset_n)
    fetchSp && vecValid |=> fetchPc && vecAddr == RESET_VEC_ADDR) // [RQ5]
    else $error("start word not fetched after stack word");

  c_reset_done: cover property (@(posedge clock) disable iff (!reset_n)
    fetchPc && vecValid);
  c_process_stack: cover property (@(posedge clock) disable iff (!reset_n)
    useProcess && spWrite);
  c_block_abandon: cover property (@(posedge clock) disable iff (!reset_n)
    blockBusy_r && excEntry);
  c_state_fault: cover property (@(posedge clock) disable iff (!reset_n)
    stateFault);
endmodule

// ==== ccrf_core_regs_test.sv ====
// self-checking bench for the core register set
`timescale 1ns/1ps
`define CHK(n, e, g) check(n, e, g)
module ccrf_core_regs_test;
  import ccrf_pkg::*;
  // ----------------------------------------
  // bench signals and expected words
  // ----------------------------------------
  localparam logic [31:0] MSP_INIT = 32'h20000ff0;
  localparam logic [31:0] PSP_INIT = 32'h20000800;
  localparam logic [31:0] START_WORD = 32'h00000121;
  localparam int MAX_CYCLES = 4000;
  logic clock, reset_n, vecReq, vecValid, wrEn, iaddrWe, xchgBranch;
  logic [31:0] vecAddr, vecData, rdDataA, rdDataB, wrData, iaddrIn;
  logic [3:0] rdIdxA, rdIdxB, wrIdx, flagsIn;
  logic flagsWe, moveToEn, excEntry, excReturn, excRetThread;
  logic excRetProcess, blockStart, blockDone, execAttempt;
  logic stateFault, coreRunning, handlerMode, processStackSel;
  ccrf_view_t moveView;
  logic [31:0] moveToData, moveFromData, excVector, excRestoreWord;
  logic [31:0] stackedWord, blockAddr, resumeAddr, iaddr;
  logic [5:0] excEntryNum;
  logic [5:0] codes [7] = '{6'h02, 6'h03, 6'h0b, 6'h0e, 6'h0f, 6'h10, 6'h2f};
  logic hasF [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  int errors, checksDone, cycles, k;

  // ----------------------------------------
  // device under test
  // ----------------------------------------
  ccrf_core_regs ccrf_core_regs_i (
    .clock(clock), .reset_n(reset_n), .vecReq(vecReq), .vecAddr(vecAddr),
    .vecValid(vecValid), .vecData(vecData), .rdIdxA(rdIdxA),
    .rdIdxB(rdIdxB), .rdDataA(rdDataA), .rdDataB(rdDataB), .wrEn(wrEn),
    .wrIdx(wrIdx), .wrData(wrData), .iaddrWe(iaddrWe), .iaddrIn(iaddrIn),
    .xchgBranch(xchgBranch), .flagsWe(flagsWe), .flagsIn(flagsIn),
    .moveToEn(moveToEn), .moveView(moveView), .moveToData(moveToData),
    .moveFromData(moveFromData), .excEntry(excEntry),
    .excEntryNum(excEntryNum), .excVector(excVector),
    .excReturn(excReturn), .excRestoreWord(excRestoreWord),
    .excRetThread(excRetThread), .excRetProcess(excRetProcess),
    .stackedWord(stackedWord), .blockStart(blockStart),
    .blockAddr(blockAddr), .blockDone(blockDone), .resumeAddr(resumeAddr),
    .execAttempt(execAttempt), .stateFault(stateFault),
    .coreRunning(coreRunning), .handlerMode(handlerMode),
    .processStackSel(processStackSel), .iaddr(iaddr)
  );

  // ----------------------------------------
  // clock and cycle limit
  // ----------------------------------------
  // free-running core clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge clock) begin
    cycles++;
    if (cycles == MAX_CYCLES) begin
      errors++;
      $display("[ERR] cycle limit expected %0d seen %0d", MAX_CYCLES - 1,
        cycles);
      final_report();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string n, input logic [31:0] e,
      input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic step();
    @(negedge clock);
  endtask

  // register write through the write port
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    step();
    wrIdx = i;
    wrData = d;
    wrEn = 1'b1;
    step();
    wrEn = 1'b0;
  endtask

  // combinational read on both ports
  task automatic rd(input logic [3:0] i);
    rdIdxA = i;
    rdIdxB = i;
    #1;
  endtask

  // special move write of one view
  task automatic mv(input ccrf_view_t v, input logic [31:0] d);
    step();
    moveView = v;
    moveToData = d;
    moveToEn = 1'b1;
    step();
    moveToEn = 1'b0;
  endtask

  // special move read of one view
  task automatic look(input ccrf_view_t v);
    moveView = v;
    #1;
  endtask

  task automatic flg(input logic [3:0] f);
    step();
    flagsIn = f;
    flagsWe = 1'b1;
    step();
    flagsWe = 1'b0;
  endtask

  task automatic enter(input logic [5:0] n, input logic [31:0] v);
    step();
    excEntryNum = n;
    excVector = v;
    excEntry = 1'b1;
    step();
    excEntry = 1'b0;
  endtask

  task automatic leave(input logic [31:0] w, input logic p);
    step();
    excRestoreWord = w;
    excRetProcess = p;
    excReturn = 1'b1;
    step();
    excReturn = 1'b0;
  endtask

  task automatic br(input logic [31:0] d, input logic x);
    step();
    iaddrIn = d;
    xchgBranch = x;
    iaddrWe = 1'b1;
    step();
    iaddrWe = 1'b0;
  endtask

  // one cycle of attempted execution, fault flag seen after it
  task automatic attempt(input logic e);
    step();
    execAttempt = 1'b1;
    step();
    execAttempt = 1'b0;
    `CHK("state fault", {31'h0, e}, {31'h0, stateFault});
  endtask

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    errors = 0;
    checksDone = 0;
    cycles = 0;
    {reset_n, vecValid, wrEn, iaddrWe, xchgBranch, flagsWe} = '0;
    {moveToEn, excEntry, excReturn, excRetProcess, blockStart} = '0;
    {blockDone, execAttempt, rdIdxA, rdIdxB, wrIdx, flagsIn} = '0;
    {vecData, wrData, iaddrIn, moveToData, excVector} = '0;
    {excRestoreWord, blockAddr, excEntryNum} = '0;
    excRetThread = 1'b1;
    moveView = VIEW_FLAGS;
    repeat (4) @(negedge clock);
    `CHK("fetch req", 32'h1, {31'h0, vecReq});
    `CHK("stack word addr", MSP_VEC_ADDR, vecAddr);
    reset_n = 1'b1;
    step();
    vecData = MSP_INIT;
    vecValid = 1'b1;
    step();
    `CHK("start word addr", RESET_VEC_ADDR, vecAddr);
    `CHK("running early", 32'h0, {31'h0, coreRunning});
    vecData = START_WORD;
    step();
    vecValid = 1'b0;
    `CHK("running", 32'h1, {31'h0, coreRunning});
    `CHK("start addr", 32'h00000120, iaddr);
    `CHK("reset word", 32'h01000000, stackedWord);
    rd(IDX_SP);
    `CHK("main stack", MSP_INIT, rdDataA);
    $display("test reset fetch done");
    // data registers and link hold distinct words
    for (k = 0; k < 15; k++) begin
      if (k != 13) wr(k[3:0], 32'h5a000000 + k * 32'h00010203);
    end
    for (k = 0; k < 15; k++) begin
      if (k != 13) begin
        rd(k[3:0]);
        `CHK("reg port a", 32'h5a000000 + k * 32'h00010203, rdDataA);
        `CHK("reg port b", 32'h5a000000 + k * 32'h00010203, rdDataB);
      end
    end
    $display("test data registers done");
    // stack select in thread mode
    mv(VIEW_CONTROL, 32'h00000002);
    look(VIEW_CONTROL);
    `CHK("control read", 32'h00000002, moveFromData);
    wr(IDX_SP, PSP_INIT);
    rd(IDX_SP);
    `CHK("process stack", PSP_INIT, rdDataA);
    mv(VIEW_CONTROL, 32'h00000000);
    rd(IDX_SP);
    `CHK("main stack back", MSP_INIT, rdDataA);
    mv(VIEW_CONTROL, 32'h00000002);
    $display("test stack select done");
    // every status view written with all ones, then read back
    for (k = 0; k < 7; k++) begin
      flg(4'h0);
      mv(ccrf_view_t'(k[2:0]), 32'hffffffff);
      look(VIEW_ALL);
      `CHK("all view", hasF[k] ? FLAGS_MASK : 32'h0, moveFromData);
      look(ccrf_view_t'(k[2:0]));
      `CHK("own view", hasF[k] ? FLAGS_MASK : 32'h0, moveFromData);
      `CHK("true word", (hasF[k] ? FLAGS_MASK : 32'h0) | TSTATE_MASK,
        stackedWord);
    end
    flg(4'h9);
    look(VIEW_FLAGS);
    `CHK("flags view", 32'h90000000, moveFromData);
    look(VIEW_STATE);
    `CHK("state view", 32'h0, moveFromData);
    $display("test status views done");
    // every listed exception number through entry and return
    flg(4'h5);
    for (k = 0; k < 7; k++) begin
      enter(codes[k], 32'h00000201);
      `CHK("handler", 32'h1, {31'h0, handlerMode});
      `CHK("entry addr", 32'h00000200, iaddr);
      `CHK("handler sel", 32'h0, {31'h0, processStackSel});
      rd(IDX_SP);
      `CHK("handler stack", MSP_INIT, rdDataA);
      mv(VIEW_ALL, 32'h50000000);
      look(VIEW_EXC);
      `CHK("exc view", {26'h0, codes[k]}, moveFromData);
      mv(VIEW_CONTROL, 32'h00000002);
      look(VIEW_CONTROL);
      `CHK("control handler", 32'h0, moveFromData);
      leave(32'h51000000, k[0]);
      look(VIEW_ALL);
      `CHK("after return", 32'h50000000, moveFromData);
      `CHK("thread sel", {31'h0, k[0]}, {31'h0, processStackSel});
    end
    $display("test exception numbers done");
    // state bit from vector, return word and exchanging branches
    enter(6'h0b, 32'h00000300);
    `CHK("stacked state", 32'h5000000b, stackedWord);
    attempt(1'b1);
    leave(32'h51000000, 1'b0);
    `CHK("restored state", 32'h51000000, stackedWord);
    attempt(1'b0);
    br(32'h00000400, 1'b0);
    `CHK("plain branch", 32'h51000000, stackedWord);
    br(32'h00000400, 1'b1);
    `CHK("xchg clear", 32'h50000000, stackedWord);
    `CHK("xchg addr", 32'h00000400, iaddr);
    attempt(1'b1);
    br(32'h00000501, 1'b1);
    `CHK("xchg set", 32'h51000000, stackedWord);
    `CHK("xchg addr odd", 32'h00000500, iaddr);
    $display("test state bit done");
    // interrupted block transfer resumes at its first transfer
    step();
    blockAddr = 32'h00000600;
    blockStart = 1'b1;
    step();
    blockStart = 1'b0;
    step();
    excEntryNum = 6'h10;
    excVector = 32'h00000201;
    excEntry = 1'b1;
    #1;
    `CHK("resume addr", 32'h00000600, resumeAddr);
    step();
    excEntry = 1'b0;
    excRetThread = 1'b0;
    leave(32'h51000000, 1'b1);
    `CHK("select kept", 32'h0, {31'h0, processStackSel});
    $display("test block restart done");
    final_report();
  end
endmodule

// ==== ccrf_gpr_bank.sv ====
// general-purpose data register array, two read ports, one write port
`timescale 1ns/1ps
module ccrf_gpr_bank
  import ccrf_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int COUNT = GPR_COUNT
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic wrEn,
  input wire logic [3:0] wrIdx,
  input wire logic [WIDTH-1:0] wrData,
  // read ports
  input wire logic [3:0] rdIdxA,
  input wire logic [3:0] rdIdxB,
  output logic [WIDTH-1:0] rdDataA,
  output logic [WIDTH-1:0] rdDataB
);
  // contents hold no reset value
  logic [WIDTH-1:0] mem [COUNT];
  wire wrHit = wrEn && (int'(wrIdx) < COUNT);

  always_ff @(posedge clock) begin
    if (wrHit) begin
      mem[wrIdx] <= wrData;
    end
  end

  assign rdDataA = (int'(rdIdxA) < COUNT) ? mem[rdIdxA] : '0;
  assign rdDataB = (int'(rdIdxB) < COUNT) ? mem[rdIdxB] : '0;
endmodule

// ==== ccrf_pkg.sv ====
// shared constants and types for the core register file
package ccrf_pkg;
  localparam int DATA_W = 32;
  localparam int GPR_COUNT = 13;
  localparam logic [3:0] IDX_SP = 4'hd;
  localparam logic [3:0] IDX_LINK = 4'he;
  localparam logic [3:0] IDX_IADDR = 4'hf;
  localparam logic [31:0] MSP_VEC_ADDR = 32'h00000000;
  localparam logic [31:0] RESET_VEC_ADDR = 32'h00000004;
  // status word field positions
  localparam int FLAG_N_POS = 31;
  localparam int FLAG_Z_POS = 30;
  localparam int FLAG_C_POS = 29;
  localparam int FLAG_V_POS = 28;
  localparam int FLAGS_LSB = 28;
  localparam int TSTATE_POS = 24;
  localparam int EXC_W = 6;
  localparam int CTRL_SPSEL_POS = 1;
  localparam logic [31:0] FLAGS_MASK = 32'hf0000000;
  localparam logic [31:0] EXC_MASK = 32'h0000003f;
  localparam logic [31:0] TSTATE_MASK = 32'h01000000;
  localparam logic [5:0] EXC_THREAD = 6'h00;
  localparam logic [5:0] EXC_FAULT = 6'h03;
  localparam logic [5:0] EXC_IRQ_FIRST = 6'h10;
  localparam logic [5:0] EXC_IRQ_LAST = 6'h2f;
  // view selector for special-register moves
  typedef enum logic [2:0] {
    VIEW_FLAGS = 3'b000,
    VIEW_EXC = 3'b001,
    VIEW_STATE = 3'b010,
    VIEW_FLAGS_EXC = 3'b011,
    VIEW_EXC_STATE = 3'b100,
    VIEW_FLAGS_STATE = 3'b101,
    VIEW_ALL = 3'b110,
    VIEW_CONTROL = 3'b111
  } ccrf_view_t;
  // reset sequencing states
  typedef enum logic [1:0] {
    RST_FETCH_SP = 2'b00,
    RST_FETCH_PC = 2'b01,
    RST_RUN = 2'b10
  } ccrf_rst_t;

  // mask of the fields a view covers
  function automatic logic [31:0] view_mask(input ccrf_view_t v);
    case (v)
      VIEW_FLAGS: view_mask = FLAGS_MASK;
      VIEW_EXC: view_mask = EXC_MASK;
      VIEW_STATE: view_mask = TSTATE_MASK;
      VIEW_FLAGS_EXC: view_mask = FLAGS_MASK | EXC_MASK;
      VIEW_EXC_STATE: view_mask = EXC_MASK | TSTATE_MASK;
      VIEW_FLAGS_STATE: view_mask = FLAGS_MASK | TSTATE_MASK;
      VIEW_ALL: view_mask = FLAGS_MASK | EXC_MASK | TSTATE_MASK;
      default: view_mask = 32'h00000000;
    endcase
  endfunction
endpackage

// ==== ccrf_status_word.sv ====
// combined status word with its three views
`timescale 1ns/1ps
module ccrf_status_word
  import ccrf_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // reset vector load
  input wire logic vecLoad,
  input wire logic vecBit0,
  // execution-unit updates
  input wire logic flagsWe,
  input wire logic [3:0] flagsIn,
  input wire logic excWe,
  input wire logic [5:0] excIn,
  input wire logic tstateWe,
  input wire logic tstateIn,
  input wire logic restoreWe,
  input wire logic [31:0] restoreWord,
  // special move write
  input wire logic moveWe,
  input wire ccrf_view_t moveView,
  input wire logic [31:0] moveData,
  // state
  output logic [3:0] flags,
  output logic [5:0] excNum,
  output logic tstate,
  output logic [31:0] trueWord
);
  logic [3:0] flags_r, flags_nxt;
  logic [5:0] exc_r, exc_nxt;
  logic tstate_r, tstate_nxt;
  wire [31:0] wMask = view_mask(moveView);
  wire moveFlags = moveWe && wMask[FLAG_N_POS];

  // next-state selection, hardware updates win over software moves
  always_comb begin
    flags_nxt = flags_r;
    exc_nxt = exc_r;
    tstate_nxt = tstate_r;
    if (moveFlags) begin
      flags_nxt = moveData[FLAG_N_POS:FLAGS_LSB]; // [RQ9]
    end
    // exception field and state bit ignore moves [RQ10] [RQ11]
    if (restoreWe) begin
      flags_nxt = restoreWord[FLAG_N_POS:FLAGS_LSB];
      exc_nxt = restoreWord[EXC_W-1:0];
      tstate_nxt = restoreWord[TSTATE_POS]; // [RQ14]
    end
    if (flagsWe) flags_nxt = flagsIn;
    if (excWe) exc_nxt = excIn;
    if (tstateWe) tstate_nxt = tstateIn; // [RQ14]
    if (vecLoad) tstate_nxt = vecBit0; // [RQ6]
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      exc_r <= EXC_THREAD;
      flags_r <= 4'h0;
      tstate_r <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      exc_r <= exc_nxt;
      tstate_r <= tstate_nxt;
    end
  end

  assign flags = flags_r;
  assign excNum = exc_r;
  assign tstate = tstate_r;
  // disjoint fields, reserved bits zero [RQ8] [RQ7] [RQ12] [RQ13] [RQ19]
  assign trueWord = {flags_r, 3'h0, tstate_r, 18'h0, exc_r};

  a_move_exc_kept: assert property (@(posedge clock) disable iff (!reset_n)
    moveWe && !excWe && !restoreWe |=> $stable(exc_r)) // [RQ10]
    else $error("move changed exception number");
  a_move_state_kept: assert property (@(posedge clock) disable iff (!reset_n)
    moveWe && !tstateWe && !restoreWe && !vecLoad |=> $stable(tstate_r))
    else $error("move changed state bit"); // [RQ11]
endmodule
